// ==== rtl/scf_sync_framer.v ====
// Sync channel word generator and data lane output stage with per-line checksums.
`timescale 1ns/10ps
`default_nettype none
`include "scf_map.vh"

// Operation
// [R1] Non-marker, non-window cycles send a class word for the lane content.
// [R2] 10-bit black and image class words come from programmable fields 0x015, 0x035.
// [R3] 10-bit checksum class 0x059 and training class 0x3A6 are programmable fields.
// [R4] 8-bit markers reuse the same fields, dropping their two lowest bits.
// [R5] 8-bit marker type in bits 7:5: 5 start, 6 end, 1 line start, 2 line end.
// [R6] 8-bit marker bits 4:0 carry signature, default 0x0A.
// [R7] 8-bit window word holds number in bits 4:2, rest zero, highest window wins.
// [R8] 8-bit class words are bits 9:2 of the 10-bit fields.
// [R9] Idle: lanes send training pattern, sync channel sends training class word.
// [R10] Lane training pattern is its own 10-bit field, default 0x3A6.
// [R11] 8-bit lane training pattern is bits 9:2 of that field.
// [R12] Each lane sends its own checksum at line end.
// [R13] Idle and training words never update the checksum.
// [R14] Sync channel sends checksum class word while lanes send checksums.
// [R15] 10-bit checksum polynomial x10+x9+x6+x3+x2+x+1.
// [R16] Checksum seeded at each line start, advanced per valid data word.
// [R17] Seed select zero gives all zeros, one gives all ones.
// [R18] 8-bit checksum polynomial x8+x6+x3+x2+1 with same seeding.
// [R19] Checksum covers the physical line across all windows in it.
// [R20] Pixels leave in kernels eight wide, one high, origin bottom left; the framer passes lanes straight and leaves the order to the sequencer.
// [R21] 10-bit marker type in bits 9:7, signature in 6:0, default 0x2A.
// [R22] 10-bit window word bits 2:0; overlap sends only highest window.
// [R23] Width select sets lanes, sync format and polynomial together.
// [R24] Receiver aligns on training pattern before trusting the other words.
module scf_sync_framer #(
  parameter LANES = 4,
  parameter W = 10,
  parameter WINDOWS = 8
) (
  input wire CLK,
  input wire RESET_N,
  input wire PIX_CLK,
  input wire WORD_MODE8,
  input wire CRC_SEED,
  input wire [2:0] SLOT_KIND,
  input wire [1:0] MARKER_KIND,
  input wire [WINDOWS-1:0] WINDOW_ACTIVE,
  input wire [LANES*W-1:0] LANE_DATA,
  input wire REG_WR,
  input wire [8:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  output reg [15:0] REG_RDATA,
  output reg [W-1:0] SYNC_WORD,
  output reg [LANES*W-1:0] LANE_WORD,
  output reg WORD_VALID
);

  // Configuration fields.
  reg [W-1:0] lane_training_pattern;
  reg [6:0] marker_signature;
  reg [W-1:0] black_class_code;
  reg [W-1:0] image_class_code;
  reg [W-1:0] checksum_class_code;
  reg [W-1:0] training_class_code;

  // Synchronisers for the pixel clock and every sequencer input.
  localparam SW = 1 + 1 + 1 + 3 + 2 + WINDOWS + LANES * W;
  reg [SW-1:0] in_s1;
  reg [SW-1:0] in_s2;
  reg pclk_d;
  wire pclk_sync;
  wire mode8;
  wire seed_ones;
  wire [2:0] slot;
  wire [1:0] kind;
  wire [WINDOWS-1:0] win_act;
  wire [LANES*W-1:0] lane_in;
  wire word_edge;

  // Line state shown in the status register.
  reg in_line;
  reg [2:0] last_window;

  // Checksum control, shared by all lanes.
  wire seed_load;
  wire advance;
  wire [LANES*W-1:0] lane_crc;

  // Next output values.
  reg [W-1:0] next_sync;
  reg [LANES*W-1:0] next_lane;

  // Highest active window; windows with lower numbers are hidden on overlap.
  function [2:0] top_window;
    input [WINDOWS-1:0] act;
    integer i;
    begin
      top_window = 3'h0;
      for (i = 0; i < WINDOWS; i = i + 1)
      begin
        if (act[i])
          top_window = i[2:0]; // [R22] [R7]
      end
    end
  endfunction

  // Fit a 10-bit field into the active word width, 8-bit words taking bits 9:2.
  function [W-1:0] fit_word;
    input [W-1:0] field;
    input m8;
    begin
      fit_word = m8 ? {2'h0, field[9:2]} : field; // [R4] [R8] [R11] [R23]
    end
  endfunction

  // Frame marker type code for the requested marker kind.
  function [2:0] marker_type;
    input [1:0] k;
    begin
      case (k)
        `SCF_KIND_FRAME_START: marker_type = `SCF_TYPE_FRAME_START;
        `SCF_KIND_FRAME_END: marker_type = `SCF_TYPE_FRAME_END;
        `SCF_KIND_LINE_START: marker_type = `SCF_TYPE_LINE_START;
        default: marker_type = `SCF_TYPE_LINE_END;
      endcase
    end
  endfunction

  // Every sequencer input passes two flip-flops; only the second stage is read. The register port is not synchronised.
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      in_s1 <= {SW{1'b0}};
      in_s2 <= {SW{1'b0}};
      pclk_d <= 1'b0;
    end
    else
    begin
      in_s1 <= {PIX_CLK, WORD_MODE8, CRC_SEED, SLOT_KIND, MARKER_KIND, WINDOW_ACTIVE,
        LANE_DATA};
      in_s2 <= in_s1;
      pclk_d <= pclk_sync;
    end
  end

  assign pclk_sync = in_s2[SW-1];
  assign mode8 = in_s2[SW-2];
  assign seed_ones = in_s2[SW-3];
  assign slot = in_s2[SW-4:SW-6];
  assign kind = in_s2[SW-7:SW-8];
  assign win_act = in_s2[LANES*W+WINDOWS-1:LANES*W];
  assign lane_in = in_s2[LANES*W-1:0];

  // One word per rising edge of the pixel clock.
  assign word_edge = pclk_sync & ~pclk_d;

  // A start marker opens a physical line, so one checksum covers every window in it.
  assign seed_load = word_edge && slot == `SCF_SLOT_MARKER &&
    (kind == `SCF_KIND_FRAME_START || kind == `SCF_KIND_LINE_START); // [R16] [R19]

  // Black and image words are the only valid data words.
  assign advance = word_edge &&
    (slot == `SCF_SLOT_BLACK || slot == `SCF_SLOT_IMAGE); // [R13]

  // One checksum engine per lane.
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane_crc_gen
      scf_line_crc #(
        .W(W)
      ) u_crc (
        .clk(CLK),
        .reset_n(RESET_N),
        .seed_load(seed_load),
        .seed_ones(seed_ones),
        .advance(advance),
        .mode8(mode8),
        .data(mode8 ? {2'h0, lane_in[g*W+9:g*W+2]} : lane_in[g*W+W-1:g*W]),
        .crc(lane_crc[g*W+W-1:g*W])
      );
    end
  endgenerate

  // Sync channel word selection by slot; the window number is sent only in a window slot.
  always @*
  begin
    next_sync = fit_word(training_class_code, mode8);
    case (slot)
      `SCF_SLOT_MARKER:
      begin
        if (mode8)
          next_sync = {2'h0, marker_type(kind), marker_signature[6:2]}; // [R5] [R6] [R4]
        else
          next_sync = {marker_type(kind), marker_signature}; // [R21]
      end
      `SCF_SLOT_WINDOW:
      begin
        if (mode8)
          next_sync = {5'h00, top_window(win_act), 2'h0}; // [R7]
        else
          next_sync = {7'h00, top_window(win_act)}; // [R22]
      end
      `SCF_SLOT_BLACK: next_sync = fit_word(black_class_code, mode8); // [R1] [R2] [R8]
      `SCF_SLOT_IMAGE: next_sync = fit_word(image_class_code, mode8); // [R1] [R2] [R8]
      `SCF_SLOT_CRC: next_sync = fit_word(checksum_class_code, mode8); // [R14] [R3]
      default: next_sync = fit_word(training_class_code, mode8); // [R9] [R3]
    endcase
  end

  // Lane word selection: pixel data, the line checksum, or the training pattern.
  integer k;
  always @*
  begin
    next_lane = {LANES*W{1'b0}};
    for (k = 0; k < LANES; k = k + 1)
    begin
      case (slot)
        `SCF_SLOT_BLACK, `SCF_SLOT_IMAGE:
          next_lane[k*W +: W] = mode8 ? {2'h0, lane_in[k*W+2 +: 8]} : lane_in[k*W +: W];
        `SCF_SLOT_CRC:
          next_lane[k*W +: W] = lane_crc[k*W +: W]; // [R12]
        default:
          next_lane[k*W +: W] = fit_word(lane_training_pattern, mode8); // [R9] [R10] [R11]
      endcase
    end
  end

  // Output words change only on a pixel clock edge and hold for the whole word.
  // Pixel order inside a kernel is the sequencer's job; lanes are passed straight. [R20]
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SYNC_WORD <= {W{1'b0}};
      LANE_WORD <= {LANES*W{1'b0}};
      WORD_VALID <= 1'b0;
      in_line <= 1'b0;
      last_window <= 3'h0;
    end
    else
    begin
      WORD_VALID <= word_edge;
      if (word_edge)
      begin
        SYNC_WORD <= next_sync;
        LANE_WORD <= next_lane;
        if (seed_load)
          in_line <= 1'b1;
        else if (slot == `SCF_SLOT_CRC)
          in_line <= 1'b0;
        if (slot == `SCF_SLOT_WINDOW)
          last_window <= top_window(win_act);
      end
    end
  end

  // Register writes from the control port; fields take the low bits of the data.
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      lane_training_pattern <= `SCF_RST_LANE_TRAIN; // [R10]
      marker_signature <= `SCF_RST_MARK_SIG; // [R6] [R21]
      black_class_code <= `SCF_RST_BLACK_CLASS; // [R2]
      image_class_code <= `SCF_RST_IMAGE_CLASS; // [R2]
      checksum_class_code <= `SCF_RST_CRC_CLASS; // [R3]
      training_class_code <= `SCF_RST_TRAIN_CLASS; // [R3]
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        `SCF_ADDR_LANE_TRAIN: lane_training_pattern <= REG_WDATA[W-1:0];
        `SCF_ADDR_MARK_SIG: marker_signature <= REG_WDATA[6:0];
        `SCF_ADDR_BLACK_CLASS: black_class_code <= REG_WDATA[W-1:0];
        `SCF_ADDR_IMAGE_CLASS: image_class_code <= REG_WDATA[W-1:0];
        `SCF_ADDR_CRC_CLASS: checksum_class_code <= REG_WDATA[W-1:0];
        `SCF_ADDR_TRAIN_CLASS: training_class_code <= REG_WDATA[W-1:0];
        default: ;
      endcase
    end
  end

  // Registered read data; unmapped addresses and unused upper bits read zero.
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      REG_RDATA <= 16'h0000;
    else
    begin
      case (REG_ADDR)
        `SCF_ADDR_LANE_TRAIN: REG_RDATA <= {6'h00, lane_training_pattern};
        `SCF_ADDR_MARK_SIG: REG_RDATA <= {9'h000, marker_signature};
        `SCF_ADDR_BLACK_CLASS: REG_RDATA <= {6'h00, black_class_code};
        `SCF_ADDR_IMAGE_CLASS: REG_RDATA <= {6'h00, image_class_code};
        `SCF_ADDR_CRC_CLASS: REG_RDATA <= {6'h00, checksum_class_code};
        `SCF_ADDR_TRAIN_CLASS: REG_RDATA <= {6'h00, training_class_code};
        `SCF_ADDR_STATUS: REG_RDATA <= {mode8, in_line, last_window, 1'b0, lane_crc[W-1:0]};
        default: REG_RDATA <= 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/scf_map.vh ====
// Register map, reset values, slot codes and marker codes of the sync channel framer.
`ifndef SCF_MAP_VH
`define SCF_MAP_VH

// Register addresses.
`define SCF_ADDR_LANE_TRAIN 9'h082
`define SCF_ADDR_MARK_SIG 9'h083
`define SCF_ADDR_BLACK_CLASS 9'h084
`define SCF_ADDR_IMAGE_CLASS 9'h085
`define SCF_ADDR_CRC_CLASS 9'h086
`define SCF_ADDR_TRAIN_CLASS 9'h087
`define SCF_ADDR_STATUS 9'h088

// Reset values.
`define SCF_RST_LANE_TRAIN 10'h3A6
`define SCF_RST_MARK_SIG 7'h2A
`define SCF_RST_BLACK_CLASS 10'h015
`define SCF_RST_IMAGE_CLASS 10'h035
`define SCF_RST_CRC_CLASS 10'h059
`define SCF_RST_TRAIN_CLASS 10'h3A6

// Slot codes given by the sequencer for each pixel clock word.
`define SCF_SLOT_IDLE 3'h0
`define SCF_SLOT_BLACK 3'h1
`define SCF_SLOT_IMAGE 3'h2
`define SCF_SLOT_CRC 3'h3
`define SCF_SLOT_MARKER 3'h4
`define SCF_SLOT_WINDOW 3'h5

// Marker kind selection and marker type codes.
`define SCF_KIND_FRAME_START 2'h0
`define SCF_KIND_FRAME_END 2'h1
`define SCF_KIND_LINE_START 2'h2
`define SCF_KIND_LINE_END 2'h3
`define SCF_TYPE_FRAME_START 3'h5
`define SCF_TYPE_FRAME_END 3'h6
`define SCF_TYPE_LINE_START 3'h1
`define SCF_TYPE_LINE_END 3'h2

// Generator polynomials without their leading term.
`define SCF_POLY10 10'h24F
`define SCF_POLY8 8'h4D

`endif

// ==== rtl/scf_line_crc.v ====
// Per-lane line checksum with 10-bit and 8-bit generator polynomials.
`timescale 1ns/10ps
`default_nettype none

module scf_line_crc #(
  parameter W = 10
) (
  input wire clk,
  input wire reset_n,
  input wire seed_load,
  input wire seed_ones,
  input wire advance,
  input wire mode8,
  input wire [W-1:0] data,
  output reg [W-1:0] crc
);

  // Bitwise shift of one word, most significant bit first.
  function [W-1:0] crc_step;
    input [W-1:0] state;
    input [W-1:0] word;
    input m8;
    integer i;
    reg [W-1:0] s;
    reg fb;
    begin
      s = state;
      for (i = W - 1; i >= 0; i = i - 1)
      begin
        if (m8)
        begin
          if (i <= 7)
          begin
            fb = s[7] ^ word[i];
            s = {2'h0, s[6:0], 1'b0} ^ (fb ? {2'h0, `SCF_POLY8} : {W{1'b0}});
          end
        end
        else
        begin
          fb = s[9] ^ word[i];
          s = {s[8:0], 1'b0} ^ (fb ? `SCF_POLY10 : {W{1'b0}});
        end
      end
      crc_step = s;
    end
  endfunction

  // Seeding wins over advancing; a marker word never carries data anyway.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      crc <= {W{1'b0}};
    else if (seed_load)
      crc <= mode8 ? {2'h0, {8{seed_ones}}} : {W{seed_ones}}; // [R16] [R17]
    else if (advance)
      crc <= crc_step(crc, data, mode8); // [R13] [R15] [R18]
  end

endmodule

`default_nettype wire

// ==== bench/scf_sync_framer_props.sv ====
// Port checker for the sync channel framer, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module scf_sync_framer_props (
  input wire CLK,
  input wire RESET_N,
  input wire PIX_CLK,
  input wire WORD_MODE8,
  input wire [2:0] SLOT_KIND,
  input wire [1:0] MARKER_KIND,
  input wire [7:0] WINDOW_ACTIVE,
  input wire [39:0] LANE_DATA,
  input wire [9:0] SYNC_WORD,
  input wire [39:0] LANE_WORD,
  input wire WORD_VALID
);
  // Highest active window, the one whose number is sent on overlap.
  function automatic [2:0] hi(input [7:0] a);
    integer i;
    begin
      hi = 3'h0;
      for (i = 0; i < 8; i = i + 1)
        if (a[i])
          hi = i[2:0];
    end
  endfunction
  // Marker type code for each marker kind.
  function automatic [2:0] typ(input [1:0] k);
    typ = (k == 2'h0) ? 3'h5 : (k == 2'h1) ? 3'h6 : (k == 2'h2) ? 3'h1 : 3'h2;
  endfunction
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  // Inputs are looked at three cycles back, inside their stable span around the pixel edge.
  chk_word_after_edge: assert property ($rose(PIX_CLK) |-> ##[3:5] WORD_VALID)
    else $error("no word after a pixel edge");
  chk_valid_single: assert property (WORD_VALID |=> !WORD_VALID)
    else $error("word valid held too long");
  chk_window_ten: assert property (
    WORD_VALID && $past(SLOT_KIND, 3) == 3'h5 && !$past(WORD_MODE8, 3)
    |-> SYNC_WORD == {7'h00, hi($past(WINDOW_ACTIVE, 3))})
    else $error("bad window word in wide mode");
  chk_window_eight: assert property (
    WORD_VALID && $past(SLOT_KIND, 3) == 3'h5 && $past(WORD_MODE8, 3)
    |-> SYNC_WORD == {5'h00, hi($past(WINDOW_ACTIVE, 3)), 2'h0})
    else $error("bad window word in narrow mode");
  chk_marker_ten: assert property (
    WORD_VALID && $past(SLOT_KIND, 3) == 3'h4 && !$past(WORD_MODE8, 3)
    |-> SYNC_WORD[9:7] == typ($past(MARKER_KIND, 3)))
    else $error("bad marker type in wide mode");
  chk_marker_eight: assert property (
    WORD_VALID && $past(SLOT_KIND, 3) == 3'h4 && $past(WORD_MODE8, 3)
    |-> SYNC_WORD[9:5] == {2'h0, typ($past(MARKER_KIND, 3))})
    else $error("bad marker type in narrow mode");
  chk_lane_pass: assert property (
    WORD_VALID && $past(SLOT_KIND, 3) == 3'h2 && !$past(WORD_MODE8, 3)
    |-> LANE_WORD == $past(LANE_DATA, 3))
    else $error("image data not passed to lanes");
  chk_narrow_top: assert property (
    WORD_VALID && $past(WORD_MODE8, 3) |-> SYNC_WORD[9:8] == 2'h0)
    else $error("narrow sync word uses top bits");
  cover property (WORD_VALID && $past(SLOT_KIND, 3) == 3'h3);
  cover property (WORD_VALID && $past(WORD_MODE8, 3) && $past(SLOT_KIND, 3) == 3'h4);
  cover property (WORD_VALID && $past(SLOT_KIND, 3) == 3'h5);
endmodule
bind scf_sync_framer scf_sync_framer_props u_props (.CLK(CLK), .RESET_N(RESET_N),
  .PIX_CLK(PIX_CLK), .WORD_MODE8(WORD_MODE8), .SLOT_KIND(SLOT_KIND),
  .MARKER_KIND(MARKER_KIND), .WINDOW_ACTIVE(WINDOW_ACTIVE), .LANE_DATA(LANE_DATA),
  .SYNC_WORD(SYNC_WORD), .LANE_WORD(LANE_WORD), .WORD_VALID(WORD_VALID));
`default_nettype wire

// ==== bench/scf_rx_model.sv ====
// Receiver model that collects each word column leaving the framer.
`timescale 1ns/10ps
`default_nettype none
module scf_rx_model (
  input wire CLK,
  input wire WORD_VALID,
  input wire [9:0] SYNC_WORD,
  input wire [39:0] LANE_WORD
);
  logic [9:0] sq = 10'h000;
  logic [39:0] lq = 40'h0;
  int cnt = 0;
  logic aligned = 1'b0;
  // Lanes are taken only on the valid pulse, so each word is stored and counted once.
  always @(posedge CLK)
    if (WORD_VALID)
    begin
      sq <= SYNC_WORD;
      lq <= LANE_WORD;
      cnt <= cnt + 1;
      // Lock when lane 0 equals the sync word, as in a training column; words are stored whether locked or not.
      if (LANE_WORD[9:0] == SYNC_WORD)
        aligned <= 1'b1;
    end
endmodule
`default_nettype wire

// ==== bench/scf_sync_framer_tb.sv ====
// Self-checking testbench for the sync channel framer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, v); end end
module scf_sync_framer_tb;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PIX_CLK = 1'b0;
  logic WORD_MODE8 = 1'b0;
  logic CRC_SEED = 1'b0;
  logic REG_WR = 1'b0;
  logic [2:0] SLOT_KIND = 3'h0;
  logic [1:0] MARKER_KIND = 2'h0;
  logic [7:0] WINDOW_ACTIVE = 8'h00;
  logic [39:0] LANE_DATA = 40'h0;
  logic [8:0] REG_ADDR = 9'h000;
  logic [15:0] REG_WDATA = 16'h0000;
  wire [15:0] REG_RDATA;
  wire [9:0] SYNC_WORD;
  wire [39:0] LANE_WORD;
  wire WORD_VALID;
  int num_errors = 0;
  int compares = 0;
  logic [9:0] cs [4];
  logic [8:0] ra [7] = '{9'h082, 9'h083, 9'h084, 9'h085, 9'h086, 9'h087, 9'h0F0};
  logic [15:0] rv [7] = '{16'h03A6, 16'h002A, 16'h0015, 16'h0035, 16'h0059, 16'h03A6, 16'h0000};
  scf_sync_framer dut (.CLK(CLK), .RESET_N(RESET_N), .PIX_CLK(PIX_CLK),
    .WORD_MODE8(WORD_MODE8), .CRC_SEED(CRC_SEED), .SLOT_KIND(SLOT_KIND),
    .MARKER_KIND(MARKER_KIND), .WINDOW_ACTIVE(WINDOW_ACTIVE), .LANE_DATA(LANE_DATA),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SYNC_WORD(SYNC_WORD), .LANE_WORD(LANE_WORD), .WORD_VALID(WORD_VALID));
  scf_rx_model rx (.CLK(CLK), .WORD_VALID(WORD_VALID), .SYNC_WORD(SYNC_WORD),
    .LANE_WORD(LANE_WORD));
  // Free running 40 MHz system clock.
  initial
    forever #12.5 CLK = ~CLK;
  task automatic print_verdict();
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Own bitwise checksum, most significant bit first; narrow mode uses bits 9:2.
  function automatic [9:0] crc(input [9:0] s, input [9:0] d, input m8);
    int i;
    logic fb;
    for (i = 9; i >= (m8 ? 2 : 0); i--)
    begin
      fb = (m8 ? s[7] : s[9]) ^ d[i];
      s = m8 ? {2'h0, s[6:0], 1'b0} : {s[8:0], 1'b0};
      if (fb)
        s = s ^ (m8 ? 10'h04D : 10'h24F);
    end
    return s;
  endfunction
  function automatic [39:0] lw(input [39:0] d, input m8);
    int l;
    lw = d;
    if (m8)
      for (l = 0; l < 4; l++)
        lw[l*10 +: 10] = {2'h0, d[l*10+2 +: 8]};
  endfunction
  task automatic wr(input [8:0] a, input [15:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input [8:0] a, input [15:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    repeat (2) @(posedge CLK);
    `CHK("register", e, REG_RDATA)
  endtask
  // One pixel word: inputs settle four cycles before the rising pixel edge.
  task automatic px(input [2:0] s, input [1:0] k, input [7:0] w, input [39:0] d);
    int c;
    int i;
    c = rx.cnt;
    @(posedge CLK);
    PIX_CLK <= 1'b0;
    SLOT_KIND <= s;
    MARKER_KIND <= k;
    WINDOW_ACTIVE <= w;
    LANE_DATA <= d;
    repeat (4) @(posedge CLK);
    PIX_CLK <= 1'b1;
    for (i = 0; i < 8 && rx.cnt == c; i++)
      @(posedge CLK);
    if (rx.cnt == c)
    begin
      num_errors++;
      print_verdict();
    end
  endtask
  // Idle, start marker, window, black, idle with data, image and checksum.
  task automatic t_line(input m8, input sd);
    logic [39:0] d;
    int l;
    d = 40'h9A_5C3E_71B4;
    @(posedge CLK);
    WORD_MODE8 <= m8;
    CRC_SEED <= sd;
    px(0, 0, 0, 0);
    `CHK("idle sync", m8 ? 10'h0E9 : 10'h3A6, rx.sq)
    `CHK("idle lanes", m8 ? {4{10'h0E9}} : {4{10'h3A6}}, rx.lq)
    `CHK("receiver aligned", 1'b1, rx.aligned)
    px(4, m8 ? 2'h2 : 2'h0, 0, 0);
    `CHK("start marker", m8 ? 10'h02A : 10'h2AA, rx.sq)
    px(5, 0, m8 ? 8'h24 : 8'h03, 0);
    `CHK("window", m8 ? 10'h014 : 10'h001, rx.sq)
    for (l = 0; l < 4; l++)
      cs[l] = sd ? (m8 ? 10'h0FF : 10'h3FF) : 10'h000;
    px(1, 0, 0, d);
    `CHK("black sync", m8 ? 10'h005 : 10'h015, rx.sq)
    `CHK("black lanes", lw(d, m8), rx.lq)
    for (l = 0; l < 4; l++)
      cs[l] = crc(cs[l], d[l*10 +: 10], m8);
    px(0, 0, 0, ~d);
    `CHK("idle mid line", m8 ? 10'h0E9 : 10'h3A6, rx.sq)
    px(2, 0, 0, ~d);
    `CHK("image sync", m8 ? 10'h00D : 10'h035, rx.sq)
    for (l = 0; l < 4; l++)
      cs[l] = crc(cs[l], ~d[l*10 +: 10], m8);
    px(3, 0, 0, 0);
    `CHK("checksum sync", m8 ? 10'h016 : 10'h059, rx.sq)
    `CHK("checksum lanes", {cs[3], cs[2], cs[1], cs[0]}, rx.lq)
    // Status shows the mode, a closed line, the last window and lane 0's checksum.
    rd(9'h088, {m8, 1'b0, m8 ? 3'h5 : 3'h1, 1'b0, cs[0]});
  endtask
  // Reprogrammed image class and lane training fields must reach both word widths; the signature is checked narrow only.
  task automatic t_write();
    wr(9'h085, 16'h0123);
    wr(9'h082, 16'h0155);
    wr(9'h083, 16'h0015);
    rd(9'h085, 16'h0123);
    WORD_MODE8 <= 1'b0;
    px(0, 0, 0, 0);
    `CHK("idle sync", 10'h3A6, rx.sq)
    `CHK("lane training", {4{10'h155}}, rx.lq)
    px(2, 0, 0, 0);
    `CHK("image sync", 10'h123, rx.sq)
    WORD_MODE8 <= 1'b1;
    px(2, 0, 0, 0);
    `CHK("narrow image", 10'h048, rx.sq)
    px(0, 0, 0, 0);
    `CHK("narrow training", {4{10'h055}}, rx.lq)
    px(4, 1, 0, 0);
    `CHK("narrow end marker", 10'h0C5, rx.sq)
  endtask
  initial
  begin
    int i;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CLK);
    for (i = 0; i < 7; i++)
      rd(ra[i], rv[i]);
    t_line(1'b0, 1'b0);
    t_line(1'b1, 1'b1);
    t_write();
    print_verdict();
  end
endmodule
`default_nettype wire
